// [dv/sfrp_host.sv]
// Host controller model driving the flash pins from sys_clk_i.
// Assumes 160 ns serial clock, stopped low outside frames.
`timescale 1ns/1ps
module sfrp_host (
  // Clock
  input  wire       sys_clk_i,
  // Link pins
  output reg        flash_clk_o,
  output reg        cs_n_o,
  output reg  [3:0] drv_o,
  output reg  [3:0] drv_en_o,
  input  wire [3:0] io_i
);
  reg [7:0] rx [0:31];
  initial begin
    flash_clk_o = 1'b0;
    cs_n_o = 1'b1;
    drv_o = 4'h0;
    drv_en_o = 4'h0;
  end
  function [3:0] lanes(input integer w);
    lanes = (w == 4) ? 4'hF : ((w == 2) ? 4'h3 : 4'h1);
  endfunction
  task tick(input integer n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task sclk;
    begin
      flash_clk_o <= 1'b0;
      tick(4);
      flash_clk_o <= 1'b1;
      tick(4);
    end
  endtask
  // Data changes with the falling edge, MSB first
  task send(input [23:0] v, input integer nb, input integer w);
    integer i;
    begin
      for (i = nb - w; i >= 0; i = i - w) begin
        drv_o <= 4'(v >> i) & lanes(w);
        drv_en_o <= lanes(w);
        sclk;
      end
    end
  endtask
  task frame(input [7:0] op, input integer cw, input [23:0] a, input integer aw,
             input integer dum, input integer dw, input integer n, input integer extra);
    integer k;
    integer b;
    reg [7:0] sh;
    begin
      sh = 8'h00;
      cs_n_o <= 1'b0;
      tick(4);
      send({16'h0000, op}, 8, cw);
      if (aw > 0)
        send(a, 24, aw);
      drv_en_o <= 4'h0;
      repeat (dum) sclk;
      for (k = 0; k < n; k = k + 1) begin
        for (b = 0; b < 8; b = b + dw) begin
          flash_clk_o <= 1'b0;
          tick(4);
          flash_clk_o <= 1'b1;
          tick(3);
          // Sampled late in the high phase to absorb the sync lag
          sh = (dw == 1) ? {sh[6:0], io_i[1]} :
               ((dw == 2) ? {sh[5:0], io_i[1:0]} : {sh[3:0], io_i});
          tick(1);
        end
        rx[k] = sh;
      end
      repeat (extra) sclk;
      flash_clk_o <= 1'b0;
      tick(2);
      cs_n_o <= 1'b1;
      tick(8);
    end
  endtask
endmodule

// [dv/sfrp_monitor.sv]
// Concurrent checks on the read path top-level ports.
// Assumes one sys_clk_i domain and a synchronous active-high reset.
`timescale 1ns/1ps
module sfrp_monitor (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  // Flash pins
  input wire        flash_clk_i,
  input wire        cs_n_i,
  input wire [3:0]  io_in_i,
  input wire [3:0]  io_out_o,
  input wire [3:0]  io_oe_o,
  // Configuration
  input wire [1:0]  proto_i,
  // Array read port
  input wire        mem_req_o,
  input wire [23:0] mem_addr_o,
  input wire [7:0]  mem_data_i,
  input wire        mem_valid_i,
  // Status
  input wire        active_o,
  input wire        refused_o,
  input wire [7:0]  opcode_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_fetch_wait;
    mem_req_o && !mem_valid_i && !cs_n_i;
  endsequence
  sequence s_fetch_done;
    mem_req_o && mem_valid_i;
  endsequence
  a_oe_width_legal: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("output enable pattern illegal");
  // Sync lag plus register stage bounds the release at six cycles
  a_deselect_release: assert property (cs_n_i [*6] |-> io_oe_o == 4'h0)
    else $error("lines still driven after deselect");
  a_refuse_single: assert property (refused_o |=> !refused_o)
    else $error("refusal pulse longer than one cycle");
  a_refuse_no_drive: assert property (refused_o |-> (io_oe_o == 4'h0) [*8])
    else $error("refused command drives lines");
  a_drive_selected: assert property ($rose(io_oe_o != 4'h0) |-> !cs_n_i)
    else $error("drive starts while deselected");
  a_out_steady_high: assert property ((flash_clk_i && !cs_n_i) [*4] |-> $stable(io_out_o))
    else $error("output changes in clock high phase");
  a_fetch_hold: assert property (s_fetch_wait |=> mem_req_o && $stable(mem_addr_o))
    else $error("array request dropped before answer");
  a_fetch_advance: assert property (s_fetch_done |=>
      !mem_req_o && mem_addr_o == $past(mem_addr_o) + 24'h000001)
    else $error("array address did not advance by one");
endmodule
bind sfrp_read_path sfrp_monitor mon (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .flash_clk_i(flash_clk_i),
  .cs_n_i(cs_n_i), .io_in_i(io_in_i), .io_out_o(io_out_o), .io_oe_o(io_oe_o),
  .proto_i(proto_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
  .mem_data_i(mem_data_i), .mem_valid_i(mem_valid_i), .active_o(active_o),
  .refused_o(refused_o), .opcode_o(opcode_o)
);

// [dv/tb.sv]
// Self-checking bench: host model, array model and directed read scenarios.
// Assumes the array answers one cycle after each request.
`timescale 1ns/1ps
`include "sfrp_map.vh"
module tb;
  // Discovery bytes 53h down to 34h
  localparam [255:0] TBL =
    256'h00000000_D810200C_EB29FFFF_BB27FFFF_FFFFFFFF_BB273B08_6B27EB29_07FFFFFF;
  reg         sys_clk_i, sys_rst_i, mem_valid_i, flt;
  reg  [1:0]  proto_i;
  reg  [7:0]  mem_data_i;
  wire        flash_clk, cs_n, mem_req_o, active_o, refused_o;
  wire [3:0]  io_w, io_out_o, io_oe_o, drv, drv_en;
  wire [23:0] mem_addr_o;
  wire [7:0]  opcode_o;
  integer     fails, check_count, refusals, act_cycles;
  // Released lines toggle so stale values never pass
  assign io_w = (io_oe_o & io_out_o) | (~io_oe_o & drv_en & drv) | (~io_oe_o & ~drv_en & {4{flt}});
  sfrp_host host (.sys_clk_i(sys_clk_i), .flash_clk_o(flash_clk), .cs_n_o(cs_n),
    .drv_o(drv), .drv_en_o(drv_en), .io_i(io_w));
  sfrp_read_path dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .flash_clk_i(flash_clk),
    .cs_n_i(cs_n), .io_in_i(io_w), .io_out_o(io_out_o), .io_oe_o(io_oe_o), .proto_i(proto_i),
    .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
    .mem_valid_i(mem_valid_i), .active_o(active_o), .refused_o(refused_o), .opcode_o(opcode_o));
  function [7:0] mbyte(input [23:0] a);
    mbyte = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
  endfunction
  function [7:0] expb(input [7:0] op, input [23:0] a);
    if (op != `SFRP_OP_DISC)
      expb = mbyte(a);
    else if (a[10:0] >= 11'h034 && a[10:0] <= 11'h053)
      expb = TBL[8 * (a[10:0] - 11'h034) +: 8];
    else
      expb = 8'hFF;
  endfunction
  always @(posedge sys_clk_i) begin
    mem_valid_i <= mem_req_o & ~mem_valid_i;
    mem_data_i <= mbyte(mem_addr_o);
    flt <= ~flt;
    if (refused_o === 1'b1)
      refusals <= refusals + 1;
    if (active_o === 1'b1)
      act_cycles <= act_cycles + 1;
  end
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  task chk8(input string nm, input [7:0] exp, input [7:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task chk1(input string nm, input exp, input got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error %s expected %b seen %b", nm, exp, got);
      end
    end
  endtask
  task rd(input [1:0] pr, input [7:0] op, input integer cw, input integer aw,
          input integer dum, input integer dw, input [23:0] a, input integer n);
    integer k;
    integer a0;
    begin
      a0 = act_cycles;
      proto_i <= pr;
      host.frame(op, cw, a, aw, dum, dw, n, 0);
      chk1("data phase flag", 1'b1, act_cycles > a0);
      for (k = 0; k < n; k = k + 1)
        chk8("data byte", expb(op, a + k[23:0]), host.rx[k]);
      chk8("opcode", op, opcode_o);
    end
  endtask
  task refuse(input [1:0] pr, input [7:0] op, input integer cw);
    integer r0;
    integer a0;
    begin
      r0 = refusals;
      a0 = act_cycles;
      proto_i <= pr;
      host.frame(op, cw, 24'h000000, 0, 0, 1, 0, 4);
      chk1("refused pulse", 1'b1, refusals == r0 + 1);
      chk1("refused data phase", 1'b0, act_cycles != a0);
    end
  endtask
  task t_ext;
    begin
      rd(`SFRP_PR_EXT, `SFRP_OP_READ, 1, 1, 0, 1, 24'hFFFFFE, 4);
      rd(`SFRP_PR_EXT, `SFRP_OP_FAST, 1, 1, 8, 1, 24'h123456, 2);
      rd(`SFRP_PR_EXT, `SFRP_OP_DOUT, 1, 1, 8, 2, 24'h00ABCD, 2);
      rd(`SFRP_PR_EXT, `SFRP_OP_DIO, 1, 2, 7, 2, 24'h5A5A00, 2);
      rd(`SFRP_PR_EXT, `SFRP_OP_QOUT, 1, 1, 7, 4, 24'h800001, 2);
      rd(`SFRP_PR_EXT, `SFRP_OP_QIO, 1, 4, 9, 4, 24'hC3C3C3, 2);
      $display("Test t_ext done");
    end
  endtask
  task t_multi;
    begin
      rd(`SFRP_PR_DUAL, `SFRP_OP_FAST, 2, 2, 7, 2, 24'h000010, 2);
      rd(`SFRP_PR_DUAL, `SFRP_OP_DOUT, 2, 2, 7, 2, 24'h0F0F0F, 2);
      rd(`SFRP_PR_DUAL, `SFRP_OP_DIO, 2, 2, 7, 2, 24'h7FFFFF, 2);
      rd(`SFRP_PR_QUAD, `SFRP_OP_FAST, 4, 4, 9, 4, 24'h246800, 2);
      rd(`SFRP_PR_QUAD, `SFRP_OP_QOUT, 4, 4, 9, 4, 24'h13579B, 2);
      rd(`SFRP_PR_QUAD, `SFRP_OP_QIO, 4, 4, 9, 4, 24'hFEDCBA, 2);
      rd(2'h3, `SFRP_OP_FAST, 1, 1, 8, 1, 24'h0000F0, 2);
      $display("Test t_multi done");
    end
  endtask
  task t_refuse;
    begin
      refuse(`SFRP_PR_EXT, 8'h9F, 1);
      refuse(`SFRP_PR_DUAL, `SFRP_OP_READ, 2);
      refuse(`SFRP_PR_DUAL, `SFRP_OP_QOUT, 2);
      refuse(`SFRP_PR_DUAL, `SFRP_OP_QIO, 2);
      refuse(`SFRP_PR_QUAD, `SFRP_OP_READ, 4);
      refuse(`SFRP_PR_QUAD, `SFRP_OP_DOUT, 4);
      refuse(`SFRP_PR_QUAD, `SFRP_OP_DIO, 4);
      $display("Test t_refuse done");
    end
  endtask
  task t_disc;
    begin
      rd(`SFRP_PR_EXT, `SFRP_OP_DISC, 1, 1, 8, 1, 24'h000034, 32);
      rd(`SFRP_PR_DUAL, `SFRP_OP_DISC, 2, 2, 8, 2, 24'h000846, 2);
      rd(`SFRP_PR_QUAD, `SFRP_OP_DISC, 4, 4, 10, 4, 24'h00083A, 2);
      $display("Test t_disc done");
    end
  endtask
  // Deselect in mid-byte, then a back-to-back frame
  task t_abort;
    begin
      proto_i <= `SFRP_PR_EXT;
      host.frame(`SFRP_OP_READ, 1, 24'h000100, 1, 0, 1, 1, 3);
      chk1("lines released", 1'b1, io_oe_o == 4'h0);
      chk1("data phase flag", 1'b0, active_o);
      rd(`SFRP_PR_EXT, `SFRP_OP_READ, 1, 1, 0, 1, 24'h000200, 2);
      $display("Test t_abort done");
    end
  endtask
  task summarize;
    begin
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    sys_rst_i = 1'b1;
    proto_i = 2'h0;
    mem_valid_i = 1'b0;
    mem_data_i = 8'h00;
    flt = 1'b0;
    fails = 0;
    check_count = 0;
    refusals = 0;
    act_cycles = 0;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    t_ext;
    t_multi;
    t_refuse;
    t_disc;
    t_abort;
    summarize;
  end
endmodule

// [src/sfrp_fifo.v]
// Prefetch FIFO between the array fetch engine and the serial output shifter.
// Assumes both sides run on sys_clk_i; flush empties it in one cycle.
`timescale 1ns/1ps
module sfrp_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  // Clock and reset
  input  wire          sys_clk_i,
  input  wire          sys_rst_i,
  input  wire          flush_i,
  // Filling side
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [W-1:0]  in_data_i,
  // Draining side
  output wire          out_valid_o,
  input  wire          out_ready_i,
  output wire [W-1:0]  out_data_o
);

  reg  [W-1:0]  mem [0:D-1];
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [AW:0]   count;
  wire          push;
  wire          pop;

  assign in_ready_o  = (count != D[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i || flush_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// [src/sfrp_map.vh]
// Constants for the serial flash read path: protocol and line-width codes,
// read opcodes, phase lengths, dummy clock counts and the discovery table.
// Assumes it is included by every design file that needs these names.
`ifndef SFRP_MAP_VH
`define SFRP_MAP_VH

// Protocol codes on proto_i
`define SFRP_PR_EXT     2'h0
`define SFRP_PR_DUAL    2'h1
`define SFRP_PR_QUAD    2'h2

// Line width codes: 1, 2 or 4 lines
`define SFRP_W1         2'h0
`define SFRP_W2         2'h1
`define SFRP_W4         2'h2

// Read opcodes, then the two erase opcodes listed in the discovery table
`define SFRP_OP_READ    8'h03
`define SFRP_OP_FAST    8'h0B
`define SFRP_OP_DOUT    8'h3B
`define SFRP_OP_DIO     8'hBB
`define SFRP_OP_QOUT    8'h6B
`define SFRP_OP_QIO     8'hEB
`define SFRP_OP_DISC    8'h5A
`define SFRP_OP_ERS1    8'h20
`define SFRP_OP_ERS2    8'hD8

// Phase lengths in bits, and a single step
`define SFRP_CMD_BITS   6'h08
`define SFRP_ADDR_BITS  6'h18
`define SFRP_BYTE_BITS  4'h8
`define SFRP_ONE6       6'h01
`define SFRP_ONE4       4'h1
`define SFRP_ONE3       3'h1

// Dummy clock counts
`define SFRP_DUM_NONE   5'h00
`define SFRP_DUM_FAST   5'h08
`define SFRP_DUM_112    5'h08
`define SFRP_DUM_122    5'h07
`define SFRP_DUM_114    5'h07
`define SFRP_DUM_144    5'h09
`define SFRP_DUM_222    5'h07
`define SFRP_DUM_444    5'h09
`define SFRP_DUM_DSTD   5'h08
`define SFRP_DUM_DQUAD  5'h0A

// Mode-bit fields of the dummy bytes
`define SFRP_MB_ONE     3'h1
`define SFRP_MB_NONE    3'h0

// Output enables per data width
`define SFRP_OE_NONE    4'h0
`define SFRP_OE_W1      4'h2
`define SFRP_OE_W2      4'h3
`define SFRP_OE_W4      4'hF

// Pin synchroniser reset: chip select idle high, clock and lines low
`define SFRP_PIN_RST    6'h20

// Discovery table window, wrap at 2048 bytes, fill for other bytes
`define SFRP_TBL_LO     11'h034
`define SFRP_TBL_HI     11'h053
`define SFRP_TBL_FILL   8'hFF
`define SFRP_DISC_PAD   13'h0000
`define SFRP_DISC_STEP  11'h001
`define SFRP_BYTE_ONES  8'hFF

// Bytes 53h down to 34h, byte 34h in the low eight bits
`define SFRP_TBL_BYTES { \
  8'h00, 8'h00, 8'h00, 8'h00, \
  `SFRP_OP_ERS2, 8'h10, `SFRP_OP_ERS1, 8'h0C, \
  `SFRP_OP_QIO, {`SFRP_MB_ONE, `SFRP_DUM_444}, 8'hFF, 8'hFF, \
  `SFRP_OP_DIO, {`SFRP_MB_ONE, `SFRP_DUM_222}, \
  8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, \
  {3'h7, 1'b1, 3'h7, 1'b1}, \
  `SFRP_OP_DIO, {`SFRP_MB_ONE, `SFRP_DUM_122}, \
  `SFRP_OP_DOUT, {`SFRP_MB_NONE, `SFRP_DUM_112}, \
  `SFRP_OP_QOUT, {`SFRP_MB_ONE, `SFRP_DUM_114}, \
  `SFRP_OP_QIO, {`SFRP_MB_ONE, `SFRP_DUM_144}, \
  8'h07, 8'hFF, 8'hFF, 8'hFF }

// Prefetch FIFO shape
`define SFRP_FIFO_W     8
`define SFRP_FIFO_D     16
`define SFRP_FIFO_AW    4

`endif

// [src/sfrp_read_path.v]
// Read side of a serial NOR flash: command, address, dummy and data phases,
// array prefetch through a FIFO, and the discovery parameter table.
// Assumes pins are asynchronous to sys_clk_i and the serial clock runs at
// most about a sixth of sys_clk_i; the array port answers on sys_clk_i.
//
// Overview of operation
// - Memory accesses use a 24-bit byte address, bits 23 to 0.
// - Every address bit is captured on a rising serial clock edge.
// - Reads start anywhere; address advances by one after every data byte.
// - Raising select ends the read; the device releases the lines three sys_clk_i cycles later.
// - Decoded read opcodes: 03, 0B, 3B, BB, 6B, EB.
// - Extended: opcode on line zero; address and data lines follow the command.
// - Dual and quad accept only their own fast reads; plain read refused.
// - Fast reads insert dummy clocks between address and first data.
// - Table 34h-37h: size in bits minus one, FFh FFh FFh 07h.
// - Byte 38h: 1-4-4 dummy 01001b, mode 001b; byte 39h EBh.
// - Byte 3Ah: 1-1-4 dummy 00111b, mode 001b; byte 3Bh 6Bh.
// - Byte 3Ch: 1-1-2 dummy 01000b, mode 000b; byte 3Dh 3Bh.
// - Byte 3Eh: 1-2-2 dummy 00111b, mode 001b; byte 3Fh BBh.
// - Byte 40h flags 2-2-2 and 4-4-4 support; reserved bits read ones.
// - Byte 46h: 2-2-2 dummy 00111b, mode 001b; byte 47h BBh.
// - Byte 4Ah: 4-4-4 dummy 01001b, mode 001b; byte 4Bh EBh.
// - Erase types: 0Ch/20h, 10h/D8h; types 3 and 4 read zero.
// - Table read: 3 address bytes, 8 or 10 dummies, wraps at 2048.
`timescale 1ns/1ps
`include "sfrp_map.vh"
module sfrp_read_path (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // Flash pins
  input  wire        flash_clk_i,
  input  wire        cs_n_i,
  input  wire [3:0]  io_in_i,
  output reg  [3:0]  io_out_o,
  output reg  [3:0]  io_oe_o,
  // Configuration
  input  wire [1:0]  proto_i,
  // Array read port
  output reg         mem_req_o,
  output reg  [23:0] mem_addr_o,
  input  wire [7:0]  mem_data_i,
  input  wire        mem_valid_i,
  // Status
  output reg         active_o,
  output reg         refused_o,
  output reg  [7:0]  opcode_o
);

  localparam S_CMD   = 3'h0;
  localparam S_ADDR  = 3'h1;
  localparam S_DUMMY = 3'h2;
  localparam S_DATA  = 3'h3;
  localparam S_REJ   = 3'h4;

  // Pin synchronisers; only the second stage is read
  reg  [5:0]   pin_s1;
  reg  [5:0]   pin_s2;
  reg          sck_d;
  wire         cs_s;
  wire         sck_s;
  wire [3:0]   io_s;
  wire         rise;
  wire         fall;

  // Link state
  reg  [2:0]   state;
  reg  [5:0]   cnt;
  reg  [1:0]   in_w;
  reg  [1:0]   out_w;
  reg  [23:0]  sh_in;
  reg  [4:0]   dum;
  reg          disc;
  reg  [7:0]   out_sh;
  reg  [2:0]   bcnt;
  reg          start;

  // Fetch engine
  reg          f_on;
  reg          f_disc;

  reg  [23:0]  next_sh;
  reg  [1:0]   pw;
  reg          dec_ok;
  reg  [1:0]   dec_aw;
  reg  [1:0]   dec_dw;
  reg  [4:0]   dec_dum;
  reg          dec_disc;

  wire [5:0]   cmd_last;
  wire [5:0]   addr_last;
  wire [5:0]   dum_last;
  wire [3:0]   beats;
  wire [3:0]   step;
  wire [7:0]   load_byte;
  wire         f_in_ready;
  wire         f_out_valid;
  wire [7:0]   f_out_data;
  wire         f_pop;
  wire         f_push;
  wire [7:0]   f_in_data;
  wire [255:0] tbl_bits;
  wire [10:0]  ta;
  wire [10:0]  toff;
  wire         tbl_hit;
  wire [7:0]   tbl_byte;

  assign cs_s  = pin_s2[5];
  assign sck_s = pin_s2[4];
  assign io_s  = pin_s2[3:0];
  assign rise  = sck_s & ~sck_d & ~cs_s;
  assign fall  = ~sck_s & sck_d & ~cs_s;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_s1 <= `SFRP_PIN_RST;
      pin_s2 <= `SFRP_PIN_RST;
      sck_d  <= 1'b0;
    end else begin
      pin_s1 <= {cs_n_i, flash_clk_i, io_in_i};
      pin_s2 <= pin_s1;
      sck_d  <= sck_s;
    end
  end

  // Command lines follow the protocol; unknown codes act as extended
  always @* begin
    case (proto_i)
      `SFRP_PR_DUAL: pw = `SFRP_W2;
      `SFRP_PR_QUAD: pw = `SFRP_W4;
      default:       pw = `SFRP_W1;
    endcase
  end

  // MSB first shift on the active input lines
  always @* begin
    case (in_w)
      `SFRP_W2: next_sh = {sh_in[21:0], io_s[1:0]};
      `SFRP_W4: next_sh = {sh_in[19:0], io_s};
      default:  next_sh = {sh_in[22:0], io_s[0]};
    endcase
  end

  // Opcode decode per protocol
  always @* begin
    dec_ok   = 1'b0;
    dec_aw   = pw;
    dec_dw   = pw;
    dec_dum  = `SFRP_DUM_NONE;
    dec_disc = 1'b0;
    case (next_sh[7:0])
      `SFRP_OP_READ: begin
        dec_ok = (pw == `SFRP_W1);
        dec_dw = `SFRP_W1;
      end
      `SFRP_OP_FAST: begin
        dec_ok  = 1'b1;
        dec_dum = (pw == `SFRP_W4) ? `SFRP_DUM_444 :
                  (pw == `SFRP_W2) ? `SFRP_DUM_222 : `SFRP_DUM_FAST;
      end
      `SFRP_OP_DOUT: begin
        dec_ok  = (pw != `SFRP_W4);
        dec_dw  = `SFRP_W2;
        dec_dum = (pw == `SFRP_W2) ? `SFRP_DUM_222 : `SFRP_DUM_112;
      end
      `SFRP_OP_DIO: begin
        dec_ok  = (pw != `SFRP_W4);
        dec_aw  = `SFRP_W2;
        dec_dw  = `SFRP_W2;
        dec_dum = (pw == `SFRP_W2) ? `SFRP_DUM_222 : `SFRP_DUM_122;
      end
      `SFRP_OP_QOUT: begin
        dec_ok  = (pw != `SFRP_W2);
        dec_dw  = `SFRP_W4;
        dec_dum = (pw == `SFRP_W4) ? `SFRP_DUM_444 : `SFRP_DUM_114;
      end
      `SFRP_OP_QIO: begin
        dec_ok  = (pw != `SFRP_W2);
        dec_aw  = `SFRP_W4;
        dec_dw  = `SFRP_W4;
        dec_dum = (pw == `SFRP_W4) ? `SFRP_DUM_444 : `SFRP_DUM_144;
      end
      `SFRP_OP_DISC: begin
        dec_ok   = 1'b1;
        dec_disc = 1'b1;
        dec_dum  = (pw == `SFRP_W4) ? `SFRP_DUM_DQUAD : `SFRP_DUM_DSTD;
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end

  assign cmd_last  = (`SFRP_CMD_BITS >> in_w) - `SFRP_ONE6;
  assign addr_last = (`SFRP_ADDR_BITS >> in_w) - `SFRP_ONE6;
  assign dum_last  = {1'b0, dum} - `SFRP_ONE6;
  assign beats     = `SFRP_BYTE_BITS >> out_w;
  assign step      = `SFRP_ONE4 << out_w;

  // Underrun shows all ones rather than stale data
  assign f_pop     = (state == S_DATA) & fall & (bcnt == 3'h0);
  assign load_byte = f_out_valid ? f_out_data : `SFRP_BYTE_ONES;

  function [3:0] drive_bits;
    input [7:0] b;
    input [1:0] w;
    begin
      case (w)
        `SFRP_W2: drive_bits = {2'b00, b[7:6]};
        `SFRP_W4: drive_bits = b[7:4];
        default:  drive_bits = {2'b00, b[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] drive_oe;
    input [1:0] w;
    begin
      case (w)
        `SFRP_W2: drive_oe = `SFRP_OE_W2;
        `SFRP_W4: drive_oe = `SFRP_OE_W4;
        default:  drive_oe = `SFRP_OE_W1;
      endcase
    end
  endfunction

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state     <= S_CMD;
      cnt       <= 6'h00;
      in_w      <= `SFRP_W1;
      out_w     <= `SFRP_W1;
      sh_in     <= 24'h000000;
      dum       <= `SFRP_DUM_NONE;
      disc      <= 1'b0;
      out_sh    <= 8'h00;
      bcnt      <= 3'h0;
      start     <= 1'b0;
      io_out_o  <= 4'h0;
      io_oe_o   <= `SFRP_OE_NONE;
      active_o  <= 1'b0;
      refused_o <= 1'b0;
      opcode_o  <= 8'h00;
    end else begin
      start     <= 1'b0;
      refused_o <= 1'b0;
      if (cs_s) begin
        state    <= S_CMD;
        cnt      <= 6'h00;
        in_w     <= pw;
        io_oe_o  <= `SFRP_OE_NONE;
        active_o <= 1'b0;
      end else begin
        case (state)
          S_CMD: begin
            if (rise) begin
              sh_in <= next_sh;
              if (cnt == cmd_last) begin
                cnt <= 6'h00;
                if (dec_ok) begin
                  state    <= S_ADDR;
                  in_w     <= dec_aw;
                  out_w    <= dec_dw;
                  dum      <= dec_dum;
                  disc     <= dec_disc;
                  opcode_o <= next_sh[7:0];
                end else begin
                  state     <= S_REJ;
                  refused_o <= 1'b1;
                end
              end else begin
                cnt <= cnt + `SFRP_ONE6;
              end
            end
          end
          S_ADDR: begin
            if (rise) begin
              sh_in <= next_sh;
              if (cnt == addr_last) begin
                cnt   <= 6'h00;
                start <= 1'b1;
                bcnt  <= 3'h0;
                state <= (dum == `SFRP_DUM_NONE) ? S_DATA : S_DUMMY;
              end else begin
                cnt <= cnt + `SFRP_ONE6;
              end
            end
          end
          S_DUMMY: begin
            if (rise) begin
              if (cnt == dum_last) begin
                cnt   <= 6'h00;
                state <= S_DATA;
              end else begin
                cnt <= cnt + `SFRP_ONE6;
              end
            end
          end
          S_DATA: begin
            active_o <= 1'b1;
            if (fall) begin
              io_oe_o <= drive_oe(out_w);
              if (bcnt == 3'h0) begin
                io_out_o <= drive_bits(load_byte, out_w);
                out_sh   <= load_byte << step;
                bcnt     <= beats[2:0] - `SFRP_ONE3;
              end else begin
                io_out_o <= drive_bits(out_sh, out_w);
                out_sh   <= out_sh << step;
                bcnt     <= bcnt - `SFRP_ONE3;
              end
            end
          end
          S_REJ: begin
            io_oe_o <= `SFRP_OE_NONE;
          end
          default: begin
            state <= S_CMD;
          end
        endcase
      end
    end
  end

  // Discovery table lookup
  assign tbl_bits = `SFRP_TBL_BYTES;
  assign ta       = mem_addr_o[10:0];
  assign toff     = ta - `SFRP_TBL_LO;
  assign tbl_hit  = (ta >= `SFRP_TBL_LO) && (ta <= `SFRP_TBL_HI);
  assign tbl_byte = tbl_hit ? tbl_bits[{toff[4:0], 3'b000} +: 8] : `SFRP_TBL_FILL;

  assign f_push    = f_on & ~cs_s & (f_disc | (mem_req_o & mem_valid_i));
  assign f_in_data = f_disc ? tbl_byte : mem_data_i;

  // Fetch runs ahead of the link; a full FIFO stalls it
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      f_on       <= 1'b0;
      f_disc     <= 1'b0;
      mem_req_o  <= 1'b0;
      mem_addr_o <= 24'h000000;
    end else if (start) begin
      f_on       <= 1'b1;
      f_disc     <= disc;
      mem_addr_o <= sh_in;
      // Ask at once: plain read has no dummies to hide the first fetch
      mem_req_o  <= ~disc;
    end else if (cs_s) begin
      f_on      <= 1'b0;
      mem_req_o <= 1'b0;
    end else if (f_on) begin
      if (f_disc) begin
        if (f_in_ready) begin
          mem_addr_o <= {`SFRP_DISC_PAD, ta + `SFRP_DISC_STEP};
        end
      end else if (mem_req_o) begin
        if (mem_valid_i) begin
          mem_req_o  <= 1'b0;
          mem_addr_o <= mem_addr_o + 24'h000001;
        end
      end else if (f_in_ready) begin
        mem_req_o <= 1'b1;
      end
    end
  end

  sfrp_fifo #(
    .W  (`SFRP_FIFO_W),
    .D  (`SFRP_FIFO_D),
    .AW (`SFRP_FIFO_AW)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .flush_i     (cs_s),
    .in_valid_i  (f_push),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_out_data)
  );

endmodule
